// ==== rdpc_pkg.sv ====
// constants for the read data parity checker
package rdpc_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned LANES = 8;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned REG_AW = 5;

  // register byte offsets
  localparam logic [REG_AW-1:0] OFS_FEATURE = 5'h00;
  localparam logic [REG_AW-1:0] OFS_STATUS = 5'h04;
  localparam logic [REG_AW-1:0] OFS_MASK = 5'h08;
  localparam logic [REG_AW-1:0] OFS_LOG_ADDR = 5'h0c;
  localparam logic [REG_AW-1:0] OFS_LOG_CTRL = 5'h10;
  localparam logic [REG_AW-1:0] OFS_ERR_COUNT = 5'h14;

  // feature control register fields
  localparam int unsigned FEAT_MCE_BIT = 0;
  localparam int unsigned FEAT_DUAL_BIT = 1;
  // status and mask fields
  localparam int unsigned ST_PARITY_BIT = 0;
  localparam int unsigned ST_LOGGED_BIT = 1;
  localparam int unsigned ST_W = 2;
  // log control fields
  localparam int unsigned LOG_CTRL_LSB = 0;
  localparam int unsigned LOG_LANE_LSB = 8;

  // reset values
  localparam logic [1:0] FEATURE_RST = 2'h0;
  localparam logic [ST_W-1:0] STATUS_RST = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST = 2'h0;
  localparam logic [ADDR_W-1:0] LOG_ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] LOG_CTRL_RST = 16'h0000;
  localparam logic [15:0] ERR_COUNT_RST = 16'h0000;

  // delay stages from burst ready to status output
  localparam int unsigned DELAY_SINGLE = 2;
  localparam int unsigned DELAY_DUAL = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rdpc_pkg

// ==== rdpc_top.sv ====
// read data parity checker with axi4-lite registers and interrupt
`timescale 1ns/1ps

// How it works
// R01 - check parity on read cycles only
// R02 - status low two clocks after burst ready
// R03 - one low clock per erroneous clock
// R04 - invalid byte lanes never flag errors
// R05 - dual mode delays status to three clocks
// R06 - enable sampled low captures address and control
// R07 - capture plus enable bit raises machine check
// R08 - system drives exception enable with bad read
// R09 - even parity, one bit per byte
module rdpc_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // processor bus side, synchronous to CLK_SYS
  input wire logic BURST_READY_N,
  input wire logic READ_CYCLE,
  input wire logic [rdpc_pkg::DATA_W-1:0] READ_DATA,
  input wire logic [rdpc_pkg::LANES-1:0] READ_PARITY,
  input wire logic [rdpc_pkg::LANES-1:0] BYTE_VALID,
  input wire logic PARITY_EXCEPTION_ENABLE_N,
  input wire logic [rdpc_pkg::ADDR_W-1:0] CYCLE_ADDR,
  input wire logic [rdpc_pkg::CTRL_W-1:0] CYCLE_CTRL,
  output logic PARITY_ERROR_STATUS_N,
  // core side machine check
  input wire logic MACHINE_CHECK_ACK,
  output logic MACHINE_CHECK_REQ,
  // axi4-lite slave
  input wire logic [rdpc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [rdpc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // interrupt
  output logic IRQ
);

  logic [rdpc_pkg::LANES-1:0] lane_bad;
  logic detect;
  logic log_now;
  logic err1_q;
  logic err2_q;
  logic parity_error_status_n_n_q;
  logic mce_q;
  logic dual_q;
  logic mcreq_q;
  logic [rdpc_pkg::ST_W-1:0] status_q;
  logic [rdpc_pkg::ST_W-1:0] mask_q;
  logic [rdpc_pkg::ST_W-1:0] st_set;
  logic [rdpc_pkg::ST_W-1:0] st_clr;
  logic [rdpc_pkg::ADDR_W-1:0] log_addr_q;
  logic [15:0] log_ctrl_q;
  logic [15:0] err_count_q;
  logic irq_q;

  // bus slave state
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [rdpc_pkg::REG_AW-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_do;
  logic wr_lo;
  logic [rdpc_pkg::REG_AW-1:0] raddr;
  logic [31:0] rd_val;
  logic rd_hit;

  // per-lane even parity over eight data bits and one parity bit
  genvar g;
  generate
    for (g = 0; g < rdpc_pkg::LANES; g++)
    begin : g_lane
      assign lane_bad[g] = BYTE_VALID[g] & // R04
        (^{READ_DATA[8*g +: 8], READ_PARITY[g]}); // R09
    end
  endgenerate

  // only a returned read word is judged
  assign detect = ~BURST_READY_N & READ_CYCLE & (|lane_bad); // R01
  assign log_now = detect & ~PARITY_EXCEPTION_ENABLE_N; // R06 R08

  // delay line from burst ready clock to status pin
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      err1_q <= 1'b0;
      err2_q <= 1'b0;
      parity_error_status_n_n_q <= 1'b1;
    end
    else
    begin
      err1_q <= detect;
      err2_q <= err1_q;
      // each erroneous clock yields exactly one low clock
      parity_error_status_n_n_q <= dual_q ? ~err2_q : ~err1_q; // R02 R03 R05
    end
  end

  // machine check capture of the failing cycle
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      log_addr_q <= rdpc_pkg::LOG_ADDR_RST;
      log_ctrl_q <= rdpc_pkg::LOG_CTRL_RST;
    end
    else if (log_now)
    begin
      log_addr_q <= CYCLE_ADDR; // R06
      log_ctrl_q <= {lane_bad, CYCLE_CTRL}; // R06
    end
  end

  // request stays up until the core takes it; a new capture with mce_q set wins over ack
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      mcreq_q <= 1'b0;
    else if (log_now && mce_q)
      mcreq_q <= 1'b1; // R07
    else if (MACHINE_CHECK_ACK)
      mcreq_q <= 1'b0;
  end

  // error counter saturates instead of wrapping
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      err_count_q <= rdpc_pkg::ERR_COUNT_RST;
    else if (detect && err_count_q != 16'hffff)
      err_count_q <= err_count_q + 16'h0001;
  end

  // sticky status, set wins over write-one-to-clear
  assign st_set = {log_now, detect};
  assign st_clr = (wr_do && wr_lo && waddr_q == rdpc_pkg::OFS_STATUS) ?
    wdata_q[rdpc_pkg::ST_W-1:0] : '0;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      status_q <= rdpc_pkg::STATUS_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~st_clr) | st_set;
      irq_q <= |(((status_q & ~st_clr) | st_set) & mask_q);
    end
  end

  // software written controls
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_lo = wstrb_q[0];

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mce_q <= rdpc_pkg::FEATURE_RST[rdpc_pkg::FEAT_MCE_BIT];
      dual_q <= rdpc_pkg::FEATURE_RST[rdpc_pkg::FEAT_DUAL_BIT];
      mask_q <= rdpc_pkg::MASK_RST;
    end
    else if (wr_do && wr_lo)
    begin
      if (waddr_q == rdpc_pkg::OFS_FEATURE)
      begin
        mce_q <= wdata_q[rdpc_pkg::FEAT_MCE_BIT];
        // switching delay mid-burst may merge or drop one status clock
        dual_q <= wdata_q[rdpc_pkg::FEAT_DUAL_BIT];
      end
      if (waddr_q == rdpc_pkg::OFS_MASK)
        mask_q <= wdata_q[rdpc_pkg::ST_W-1:0];
    end
  end

  // write channels taken independently, response after both
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= rdpc_pkg::RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && awready_q)
      begin
        waddr_q <= S_AXI_AWADDR[rdpc_pkg::REG_AW-1:0];
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q)
      begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_do)
      begin
        bvalid_q <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bresp_q <= (waddr_q == rdpc_pkg::OFS_FEATURE || waddr_q == rdpc_pkg::OFS_STATUS ||
          waddr_q == rdpc_pkg::OFS_MASK) ? rdpc_pkg::RESP_OKAY : rdpc_pkg::RESP_SLVERR;
      end
      if (bvalid_q && S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read decode
  assign raddr = S_AXI_ARADDR[rdpc_pkg::REG_AW-1:0];

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (raddr)
      rdpc_pkg::OFS_FEATURE: rd_val = {30'h0, dual_q, mce_q};
      rdpc_pkg::OFS_STATUS: rd_val = {30'h0, status_q};
      rdpc_pkg::OFS_MASK: rd_val = {30'h0, mask_q};
      rdpc_pkg::OFS_LOG_ADDR: rd_val = log_addr_q;
      rdpc_pkg::OFS_LOG_CTRL: rd_val = {16'h0, log_ctrl_q};
      rdpc_pkg::OFS_ERR_COUNT: rd_val = {16'h0, err_count_q};
      default: rd_hit = 1'b0;
    endcase
    if (S_AXI_ARADDR[rdpc_pkg::ADDR_W-1:rdpc_pkg::REG_AW] != '0)
      rd_hit = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rdpc_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? rd_val : 32'h0000_0000;
      rresp_q <= rd_hit ? rdpc_pkg::RESP_OKAY : rdpc_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && S_AXI_RREADY)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign PARITY_ERROR_STATUS_N = parity_error_status_n_n_q;
  assign MACHINE_CHECK_REQ = mcreq_q;
  assign IRQ = irq_q;
  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  sequence bad_read_s;
    ~BURST_READY_N && READ_CYCLE && (|lane_bad);
  endsequence

  sequence logged_read_s;
    bad_read_s ##0 !PARITY_EXCEPTION_ENABLE_N;
  endsequence

  read_only_a: assert property (!READ_CYCLE |=> !err1_q) // R01
    else $error("parity error flagged on a non-read cycle");

  single_delay_a: assert property (bad_read_s ##1 !dual_q |-> ##1 !PARITY_ERROR_STATUS_N) // R02
    else $error("status not low two clocks after bad burst ready");

  one_low_a: assert property (!PARITY_ERROR_STATUS_N |->
      ($past(err1_q, 1) && !$past(dual_q, 1)) || ($past(err2_q, 1) && $past(dual_q, 1))) // R03
    else $error("status low without a matching error clock");

  lane_mask_a: assert property ((BYTE_VALID == 8'h00) |=> !err1_q) // R04
    else $error("error flagged with no valid byte lane");

  dual_delay_a: assert property (bad_read_s ##2 dual_q |-> ##1 !PARITY_ERROR_STATUS_N) // R05
    else $error("status not low three clocks after bad burst ready");

  capture_addr_a: assert property (logged_read_s |=> log_addr_q == $past(CYCLE_ADDR)) // R06
    else $error("failing cycle address not captured");

  mc_raise_a: assert property (logged_read_s ##0 mce_q |=> MACHINE_CHECK_REQ [*1]) // R07
    else $error("machine check not raised after capture");

  even_parity_a: assert property (~BURST_READY_N && READ_CYCLE && BYTE_VALID[0] &&
      (^{READ_DATA[7:0], READ_PARITY[0]}) |=> err1_q ##1 err2_q) // R09
    else $error("odd lane parity not detected");

endmodule : rdpc_top

// ==== rdpc_mem_model.sv ====
// partner model: memory system returning read data with byte parity
`timescale 1ns/1ps
module rdpc_mem_model (
  // clock
  input wire logic clk,
  // read return
  output logic burst_ready_n = 1'b1,
  output logic read_cycle = 1'b0,
  output logic [63:0] read_data = 64'h0,
  output logic [7:0] read_parity = 8'h0,
  output logic [7:0] byte_valid = 8'h0,
  output logic parity_exception_enable_n = 1'b1,
  output logic [31:0] cycle_addr = 32'h0,
  output logic [7:0] cycle_ctrl = 8'h0
);
  // n beats back to back; lanes set in bad carry a flipped parity bit
  task automatic burst(input int n, input logic [7:0] bad, vld, input logic rd,
                       input logic pen_n, input logic [31:0] a);
    int k;
    int g;
    logic [63:0] d;
    for (k = 0; k < n; k++)
    begin
      @(posedge clk);
      d = {a, ~a} + 64'(k);
      for (g = 0; g < 8; g++)
        read_parity[g] <= ^d[8*g+:8] ^ bad[g];
      burst_ready_n <= 1'b0;
      read_cycle <= rd;
      read_data <= d;
      byte_valid <= vld;
      parity_exception_enable_n <= pen_n;
      cycle_addr <= a;
      cycle_ctrl <= a[15:8];
    end
    @(posedge clk);
    // released data, parity, valid and address lines show garbage; read_cycle and cycle_ctrl keep the last beat
    burst_ready_n <= 1'b1;
    read_data <= ~read_data;
    read_parity <= ~read_parity;
    byte_valid <= ~byte_valid;
    parity_exception_enable_n <= 1'b1;
    cycle_addr <= ~cycle_addr;
  endtask : burst
endmodule : rdpc_mem_model

// ==== tb.sv ====
// testbench for the read data parity checker
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rstn = 1'b0, ack = 1'b0, parity_error_status_n_n, mcreq, irq;
  logic burst_ready_n_n, rcyc, pen_n;
  logic [63:0] rdat;
  logic [7:0] rpar, bval, cctrl;
  logic [31:0] caddr, rdata, awaddr = 32'h0, araddr = 32'h0, wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int miscompares = 0, n_checks = 0;

  rdpc_mem_model mem (.clk(clk), .burst_ready_n(burst_ready_n_n), .read_cycle(rcyc),
    .read_data(rdat), .read_parity(rpar), .byte_valid(bval),
    .parity_exception_enable_n(pen_n), .cycle_addr(caddr), .cycle_ctrl(cctrl));
  rdpc_top DUT (.CLK_SYS(clk), .RSTN(rstn), .BURST_READY_N(burst_ready_n_n), .READ_CYCLE(rcyc),
    .READ_DATA(rdat), .READ_PARITY(rpar), .BYTE_VALID(bval),
    .PARITY_EXCEPTION_ENABLE_N(pen_n), .CYCLE_ADDR(caddr), .CYCLE_CTRL(cctrl),
    .PARITY_ERROR_STATUS_N(parity_error_status_n_n), .MACHINE_CHECK_ACK(ack), .MACHINE_CHECK_REQ(mcreq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge clk);
    awaddr <= {27'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        chk("bresp", bresp, r);
        break;
      end
    end
    if (k == 100) chk("bvalid", 1'b0, 1'b1);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge clk);
    araddr <= {27'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
        break;
      end
    end
    if (k == 100) chk("rvalid", 1'b0, 1'b1);
  endtask : rd

  // one burst with the status output watched cycle by cycle
  task automatic run(input int n, input logic [7:0] bad, vld, input logic r, pn,
                     input int d);
    int i;
    logic err;
    err = r && ((bad & vld) != 8'h0);
    fork
      mem.burst(n, bad, vld, r, pn, 32'h0000_1230);
      begin
        @(posedge clk);
        for (i = 1; i <= n + 4; i++)
        begin
          @(posedge clk);
          #1;
          chk("status_n", parity_error_status_n_n, !(err && i >= d && i < n + d));
        end
      end
    join
  endtask : run

  task automatic t_regs;
    rd(rdpc_pkg::OFS_FEATURE, 32'h0, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_STATUS, 32'h0, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_MASK, 32'h0, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_LOG_ADDR, 32'h0, rdpc_pkg::RESP_OKAY);
    rd(5'h18, 32'h0, rdpc_pkg::RESP_SLVERR);
    wr(rdpc_pkg::OFS_LOG_ADDR, 32'hffff_ffff, rdpc_pkg::RESP_SLVERR);
    rd(rdpc_pkg::OFS_LOG_ADDR, 32'h0, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_ERR_COUNT, 32'h0, rdpc_pkg::RESP_OKAY);
    // low byte strobe off: accepted but must leave the mask alone
    wstrb <= 4'h0;
    wr(rdpc_pkg::OFS_MASK, 32'h3, rdpc_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(rdpc_pkg::OFS_MASK, 32'h0, rdpc_pkg::RESP_OKAY);
    $display("test regs done");
  endtask : t_regs

  task automatic t_parity;
    for (int g = 0; g < 8; g++)
      run(1, 8'h01 << g, 8'hff, 1'b1, 1'b1, 2);
    run(1, 8'h00, 8'hff, 1'b1, 1'b1, 2);
    run(1, 8'h0f, 8'hf0, 1'b1, 1'b1, 2);
    run(1, 8'hff, 8'hff, 1'b0, 1'b1, 2);
    run(3, 8'h81, 8'hff, 1'b1, 1'b1, 2);
    wr(rdpc_pkg::OFS_FEATURE, 32'h2, rdpc_pkg::RESP_OKAY);
    run(2, 8'h10, 8'hff, 1'b1, 1'b1, 3);
    wr(rdpc_pkg::OFS_FEATURE, 32'h0, rdpc_pkg::RESP_OKAY);
    $display("test parity done");
  endtask : t_parity

  task automatic t_log;
    wr(rdpc_pkg::OFS_STATUS, 32'h3, rdpc_pkg::RESP_OKAY);
    wr(rdpc_pkg::OFS_MASK, 32'h2, rdpc_pkg::RESP_OKAY);
    chk("irq", irq, 1'b0);
    run(1, 8'h24, 8'h2c, 1'b1, 1'b0, 2);
    chk("irq", irq, 1'b1);
    chk("mc_req", mcreq, 1'b0);
    rd(rdpc_pkg::OFS_LOG_ADDR, 32'h0000_1230, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_LOG_CTRL, 32'h0000_2412, rdpc_pkg::RESP_OKAY);
    rd(rdpc_pkg::OFS_STATUS, 32'h3, rdpc_pkg::RESP_OKAY);
    wr(rdpc_pkg::OFS_STATUS, 32'h2, rdpc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b0);
    rd(rdpc_pkg::OFS_STATUS, 32'h1, rdpc_pkg::RESP_OKAY);
    $display("test log done");
  endtask : t_log

  task automatic t_mc;
    wr(rdpc_pkg::OFS_FEATURE, 32'h1, rdpc_pkg::RESP_OKAY);
    run(1, 8'h01, 8'hff, 1'b1, 1'b1, 2);
    chk("mc_req", mcreq, 1'b0);
    run(1, 8'h01, 8'hff, 1'b1, 1'b0, 2);
    repeat (3) @(posedge clk);
    chk("mc_req", mcreq, 1'b1);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    #1;
    chk("mc_req", mcreq, 1'b0);
    rd(rdpc_pkg::OFS_FEATURE, 32'h1, rdpc_pkg::RESP_OKAY);
    // sixteen erroneous read clocks were sent since reset
    rd(rdpc_pkg::OFS_ERR_COUNT, 32'h0000_0010, rdpc_pkg::RESP_OKAY);
    $display("test machine check done");
  endtask : t_mc

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_parity();
    t_log();
    t_mc();
    wrap_up();
  end

  // whole run is well under a thousand cycles
  initial
  begin
    #(40 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule : tb
